// *** hw/dpc_defines.svh ***
// timing counts, field positions and reset values of the card front end
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
// clock rate of ref_clk in MHz
`define DPC_CLK_MHZ 125
// carrier rises per bit_period_unit, and half of it for mid-bit sampling
`define DPC_ETU_CLKS 9'd372
`define DPC_ETU_HALF 9'd186
// answer-to-reset length in characters
`define DPC_ATR_CHARS 4'd8
// characters that make one page write
`define DPC_PAGE_BYTES 5'd16
// fastest synchronous clock that the host may use, in kHz
`define DPC_SYNC_MAX_KHZ 1000
// self-timed programming time in us and its cycle count less one, loaded into the down-counter
`define DPC_PROG_US 5
`define DPC_PROG_CLKS 10'((`DPC_PROG_US * `DPC_CLK_MHZ) - 1)
// header byte fields: device address, zone, password flag, read flag
`define DPC_HDR_ADDR 7:4
`define DPC_HDR_ZONE 3:2
`define DPC_HDR_PW 1
`define DPC_HDR_RD 0
// bytes of a 24-bit password
`define DPC_PW_BYTES 2'd3
// reset values of the pad synchronisers: reset pad pulled high
`define DPC_RST_PAD_RST 2'b11
`define DPC_LINE_RST 2'b11
`endif

// *** hw/dpc_pkg.sv ***
// types of the dual protocol card front end
package dpc_pkg;
    typedef enum logic [2:0] {
        DPC_S_IDLE = 3'b000,
        DPC_S_HDR = 3'b001,
        DPC_S_OFS = 3'b010,
        DPC_S_WDATA = 3'b011,
        DPC_S_PW = 3'b100,
        DPC_S_RDATA = 3'b101,
        DPC_S_IGNORE = 3'b110
    } dpc_sync_e;
    typedef enum logic [1:0] {
        DPC_A_OFF = 2'b00,
        DPC_A_IDLE = 2'b01,
        DPC_A_RX = 2'b10,
        DPC_A_TX = 2'b11
    } dpc_async_e;
    typedef logic [16:0] dpc_word_t;
    typedef struct packed {
        logic [2:0] clk_s;
        logic [1:0] rst_s;
        logic [2:0] sda_s;
        logic async_mode;
        dpc_sync_e s_st;
        logic [3:0] s_bit;
        logic [7:0] s_sh;
        logic s_rd;
        logic s_pw;
        logic [1:0] s_zone;
        logic [6:0] s_ofs;
        logic [4:0] s_page;
        logic [7:0] s_tx;
        logic [23:0] pw_acc;
        logic [1:0] pw_cnt;
        logic pw_ok;
        logic [9:0] prog_cnt;
        logic prog_busy;
        dpc_async_e a_st;
        logic [8:0] a_cnt;
        logic [8:0] a_lim;
        logic [3:0] a_bit;
        logic [9:0] a_frame;
        logic a_err;
        logic a_atr;
        logic [3:0] a_atr_n;
        logic [63:0] a_atr_sh;
        logic sda_oe;
        logic sda_out;
        logic tx_ready;
        logic push;
        dpc_word_t push_word;
    } dpc_state_s;
endpackage

// *** hw/dpc_card_if.sv ***
// serial front end of the card: async character link and addressed 2-wire link
`timescale 1ns/1ps
`include "dpc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// two-entry buffer, output stage plus skid entry, both from flip-flops
module dpc_buf #(
    parameter int W = 17
) (
    input wire logic ref_clk, // system clock
    input wire logic reset, // async reset, high
    input wire logic in_valid, // word offered
    input wire logic [W-1:0] in_data, // offered word
    output logic in_ready, // room for a word
    output logic out_valid, // word waiting
    output logic [W-1:0] out_data, // waiting word
    input wire logic out_ready // receiver takes word
);
    typedef struct packed {
        logic v0;
        logic v1;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } dpc_buf_s;
    dpc_buf_s q;
    dpc_buf_s d;

    // pop first so a word offered as the only entry leaves goes straight to the output stage
    always_comb
    begin
        d = q;
        if (q.v0 && out_ready)
        begin
            d.d0 = q.d1;
            d.v0 = q.v1;
            d.v1 = 1'b0;
        end
        if (in_valid && !q.v1)
        begin
            if (!d.v0)
            begin
                d.d0 = in_data;
                d.v0 = 1'b1;
            end
            else
            begin
                d.d1 = in_data;
                d.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            q <= '0;
        else
            q <= d;
    end

    assign in_ready = !q.v1; // ready only while skid entry free
    assign out_valid = q.v0;
    assign out_data = q.d0;
endmodule

////////////////////////////////////////////////////////////////////////////////
module dpc_card_if (
    input wire logic ref_clk, // 125 MHz system clock
    input wire logic reset, // async reset, high
    input wire logic clk_pin, // carrier / serial clock pad
    input wire logic rst_pin, // card reset pad
    input wire logic sda_in, // data line level
    output logic sda_out, // data line drive value, always low
    output logic sda_oe, // high while pulling line low
    input wire logic [3:0] dev_addr, // own 2-wire address
    input wire logic [63:0] atr_data, // answer-to-reset, first char in [7:0]
    input wire logic [3:0] zone_wr_en, // write right per zone
    input wire logic [3:0] zone_rd_en, // read right per zone
    input wire logic crypt_en, // authentication established
    input wire logic [1:0] key_sel, // chosen key set
    input wire logic [31:0] key_bytes, // stream byte of each key set
    input wire logic [383:0] pw_sets, // eight sets of two 24-bit passwords
    output logic rx_valid, // received word waiting
    output logic [16:0] rx_data, // {zone, offset, data}
    input wire logic rx_ready, // user takes word
    input wire logic tx_valid, // user byte offered
    input wire logic [7:0] tx_data, // user byte
    output logic tx_ready, // one-cycle pulse, byte taken
    output logic async_mode, // async protocol active
    output logic prog_busy, // self-timed write running
    output logic pw_ok // last password check matched
);
    import dpc_pkg::*;

    dpc_state_s q;
    dpc_state_s d;
    logic buf_ready;
    logic [7:0] key_byte;
    logic clk_rise;
    logic clk_fall;
    logic scl_hi;
    logic sda_lvl;
    logic sda_prev;
    logic [7:0] byte_in;
    logic [23:0] pw_ref;

    // stream byte of the chosen key set, zero until authenticated
    assign key_byte = crypt_en ? key_bytes[key_sel*8 +: 8] : 8'h00;
    assign byte_in = q.s_sh ^ key_byte;
    assign pw_ref = pw_sets[{q.s_ofs[3:0], 1'b0} * 12 +: 24];
    // edges come from the second and third stages, never the first
    assign clk_rise = q.clk_s[1] && !q.clk_s[2];
    assign clk_fall = !q.clk_s[1] && q.clk_s[2];
    assign scl_hi = q.clk_s[1] && q.clk_s[2];
    assign sda_lvl = q.sda_s[1];
    assign sda_prev = q.sda_s[2];

    ////////////////////////////////////////////////////////////////////////////
    // next state of both protocol engines
    always_comb
    begin
        d = q;
        d.clk_s = {q.clk_s[1:0], clk_pin};
        d.rst_s = {q.rst_s[0], rst_pin};
        d.sda_s = {q.sda_s[1:0], sda_in};
        d.sda_out = 1'b0;
        d.tx_ready = 1'b0;
        d.push = 1'b0;
        // self-timed programming after a write
        if (q.prog_busy)
        begin
            d.prog_cnt = q.prog_cnt - 10'h001;
            if (q.prog_cnt == 10'h000)
                d.prog_busy = 1'b0;
        end
        // reset pad low selects the async protocol and holds it quiet
        if (!q.rst_s[1])
        begin
            d.async_mode = 1'b1;
            d.a_st = DPC_A_OFF;
            d.s_st = DPC_S_IDLE;
            d.sda_oe = 1'b0;
        end
        else if (q.async_mode)
        begin
            unique case (q.a_st)
                DPC_A_OFF:
                begin
                    // rising reset pad starts the answer-to-reset
                    d.a_atr_sh = atr_data;
                    d.a_atr_n = `DPC_ATR_CHARS;
                    d.a_atr = 1'b1;
                    d.a_st = DPC_A_IDLE;
                end
                DPC_A_IDLE:
                begin
                    d.sda_oe = 1'b0;
                    d.a_cnt = 9'h000;
                    d.a_bit = 4'h0;
                    d.a_lim = `DPC_ETU_CLKS;
                    // frames start on a carrier rise, so the start bit also lasts whole carrier periods
                    if (q.a_atr && q.a_atr_n != 4'h0 && !clk_rise)
                        d.a_st = DPC_A_IDLE;
                    else if (q.a_atr && q.a_atr_n != 4'h0)
                    begin
                        d.a_frame = {^q.a_atr_sh[7:0], q.a_atr_sh[7:0], 1'b0};
                        d.a_atr_sh = {8'h00, q.a_atr_sh[63:8]};
                        d.a_atr_n = q.a_atr_n - 4'h1;
                        d.a_st = DPC_A_TX;
                    end
                    else if (sda_lvl == 1'b0)
                    begin
                        // start bit seen, first sample half a bit later
                        d.a_atr = 1'b0;
                        d.a_lim = `DPC_ETU_HALF;
                        d.a_st = DPC_A_RX;
                    end
                    else if (tx_valid && !q.tx_ready && clk_rise)
                    begin
                        // half duplex: send only while the line is idle
                        d.a_atr = 1'b0;
                        d.a_frame = {^(tx_data ^ key_byte), tx_data ^ key_byte, 1'b0};
                        d.tx_ready = 1'b1;
                        d.a_st = DPC_A_TX;
                    end
                end
                DPC_A_TX:
                begin
                    // pull low only for zero bits, guard bits released
                    d.sda_oe = (q.a_bit < 4'd10) && !q.a_frame[0];
                    if (clk_rise)
                    begin
                        d.a_cnt = q.a_cnt + 9'h001;
                        if (q.a_cnt == q.a_lim - 9'h001)
                        begin
                            d.a_cnt = 9'h000;
                            d.a_bit = q.a_bit + 4'h1;
                            d.a_frame = {1'b1, q.a_frame[9:1]};
                            if (q.a_bit == 4'd11)
                                d.a_st = DPC_A_IDLE;
                        end
                    end
                end
                DPC_A_RX:
                begin
                    if (clk_rise)
                    begin
                        d.a_cnt = q.a_cnt + 9'h001;
                        if (q.a_cnt == q.a_lim - 9'h001)
                        begin
                            d.a_cnt = 9'h000;
                            d.a_lim = `DPC_ETU_CLKS;
                            d.a_bit = q.a_bit + 4'h1;
                            if (q.a_bit == 4'd0 && sda_lvl)
                                d.a_st = DPC_A_IDLE; // false start
                            else if (q.a_bit < 4'd9)
                                d.a_frame = {sda_lvl, q.a_frame[9:1]};
                            else if (q.a_bit == 4'd9)
                            begin
                                // even parity over data and parity bit
                                d.a_err = (^q.a_frame[9:2] ^ sda_lvl) || !buf_ready;
                                d.push = !(^q.a_frame[9:2] ^ sda_lvl) && buf_ready;
                                d.push_word = {9'h000, q.a_frame[9:2] ^ key_byte};
                            end
                            else if (q.a_bit == 4'd10)
                            begin
                                // error signal asks the reader to repeat
                                d.sda_oe = q.a_err;
                                if (!q.a_err)
                                    d.a_st = DPC_A_IDLE;
                            end
                            else
                            begin
                                d.sda_oe = 1'b0;
                                d.a_st = DPC_A_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
        else
        begin
            // sync engine has no answer-to-reset path at all
            if (scl_hi && sda_prev && !sda_lvl)
            begin
                d.s_st = DPC_S_HDR;
                d.s_bit = 4'h0;
                d.sda_oe = 1'b0;
            end
            else if (scl_hi && !sda_prev && sda_lvl)
            begin
                // stop ends a page and starts programming
                if (q.s_st == DPC_S_WDATA && q.s_page != 5'h00)
                begin
                    d.prog_busy = 1'b1;
                    d.prog_cnt = `DPC_PROG_CLKS;
                end
                d.s_st = DPC_S_IDLE;
                d.sda_oe = 1'b0;
            end
            else if (clk_rise && q.s_st != DPC_S_IDLE)
            begin
                if (q.s_bit < 4'd8)
                begin
                    d.s_sh = {q.s_sh[6:0], sda_lvl};
                    d.s_bit = q.s_bit + 4'h1;
                end
                else
                begin
                    d.s_bit = 4'h0;
                    if (q.s_st == DPC_S_RDATA && sda_lvl)
                        d.s_st = DPC_S_IGNORE; // host refused more data
                end
            end
            else if (clk_fall && q.s_st != DPC_S_IDLE)
            begin
                d.sda_oe = 1'b0;
                if (q.s_st == DPC_S_RDATA && q.s_bit == 4'h0)
                begin
                    d.s_tx = 8'hff;
                    if (tx_valid && zone_rd_en[q.s_zone] && !q.tx_ready)
                    begin
                        d.s_tx = tx_data ^ key_byte;
                        d.tx_ready = 1'b1;
                    end
                    d.sda_oe = !d.s_tx[7];
                end
                else if (q.s_st == DPC_S_RDATA && q.s_bit < 4'd8)
                    d.sda_oe = !q.s_tx[3'(4'd7 - q.s_bit)];
                else if (q.s_bit == 4'd8)
                begin
                    unique case (q.s_st)
                        DPC_S_HDR:
                        begin
                            if (q.s_sh[`DPC_HDR_ADDR] == dev_addr && !q.prog_busy)
                            begin
                                d.sda_oe = 1'b1;
                                d.s_rd = q.s_sh[`DPC_HDR_RD];
                                d.s_pw = q.s_sh[`DPC_HDR_PW];
                                d.s_zone = q.s_sh[`DPC_HDR_ZONE];
                                d.s_st = DPC_S_OFS;
                            end
                            else
                                d.s_st = DPC_S_IGNORE;
                        end
                        DPC_S_OFS:
                        begin
                            d.sda_oe = 1'b1;
                            d.s_ofs = q.s_sh[6:0];
                            d.s_page = 5'h00;
                            d.pw_cnt = 2'h0;
                            d.s_st = q.s_pw ? DPC_S_PW : (q.s_rd ? DPC_S_RDATA : DPC_S_WDATA);
                        end
                        DPC_S_WDATA:
                        begin
                            // refuse past the page, a locked zone or a full buffer
                            if (zone_wr_en[q.s_zone] && q.s_page < `DPC_PAGE_BYTES && buf_ready)
                            begin
                                d.sda_oe = 1'b1;
                                d.push = 1'b1;
                                d.push_word = {q.s_zone, q.s_ofs, byte_in};
                                d.s_ofs = {q.s_ofs[6:4], q.s_ofs[3:0] + 4'h1};
                                d.s_page = q.s_page + 5'h01;
                            end
                        end
                        DPC_S_PW:
                        begin
                            d.sda_oe = 1'b1;
                            d.pw_acc = {q.pw_acc[15:0], byte_in};
                            d.pw_cnt = q.pw_cnt + 2'h1;
                            if (q.pw_cnt == `DPC_PW_BYTES - 2'h1)
                                d.pw_ok = ({q.pw_acc[15:0], byte_in} == pw_ref);
                        end
                        default:
                            d.sda_oe = 1'b0;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // all state in one register; reset pad synchroniser resets high
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            q <= '0;
            q.rst_s <= `DPC_RST_PAD_RST;
            q.sda_s <= {1'b1, `DPC_LINE_RST};
            q.clk_s <= {1'b1, `DPC_LINE_RST}; // idle high, so no false clock edge after reset
            q.s_st <= DPC_S_IDLE;
            q.a_st <= DPC_A_OFF;
        end
        else
            q <= d;
    end

    // receive path buffer, back-pressure refuses acks and flags async errors
    dpc_buf #(.W(17)) u_rx_buf (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(q.push),
        .in_data(q.push_word),
        .in_ready(buf_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );

    assign sda_out = q.sda_out;
    assign sda_oe = q.sda_oe;
    assign tx_ready = q.tx_ready;
    assign async_mode = q.async_mode;
    assign prog_busy = q.prog_busy;
    assign pw_ok = q.pw_ok;
endmodule

// *** tb/dpc_card_if_asserts.sv ***
// assertions on the ports of the card front end
`timescale 1ns/1ps
module dpc_card_if_asserts (
    input wire logic ref_clk, // system clock
    input wire logic reset, // async reset, high
    input wire logic clk_pin, // clock pad
    input wire logic rst_pin, // card reset pad
    input wire logic sda_out, // drive value
    input wire logic sda_oe, // pull-low enable
    input wire logic [3:0] zone_wr_en, // write rights
    input wire logic rx_valid, // word waiting
    input wire logic [16:0] rx_data, // waiting word
    input wire logic rx_ready, // word taken
    input wire logic async_mode, // async active
    input wire logic prog_busy // programming
);
    logic [5:0] clk_h_q;
    logic [9:0] busy_n_q;
    logic fell_seen;
    logic rose_seen;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    // pad history deep enough to cover the synchroniser delay
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            clk_h_q <= 6'h00;
            busy_n_q <= 10'h000;
        end
        else
        begin
            clk_h_q <= {clk_h_q[4:0], clk_pin};
            busy_n_q <= prog_busy ? busy_n_q + 10'h001 : 10'h000;
        end
    end
    // a pad edge anywhere in the window
    assign fell_seen = |(clk_h_q[5:1] & ~clk_h_q[4:0]);
    assign rose_seen = |(~clk_h_q[5:1] & clk_h_q[4:0]);
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    property p_sync_fall; !async_mode && $changed(sda_oe) |-> fell_seen; endproperty
    a_sync_fall: assert property (p_sync_fall) else $error("sync data moved off a clock fall");
    property p_async_rise; async_mode && $changed(sda_oe) |-> rose_seen; endproperty
    a_async_rise: assert property (p_async_rise) else $error("async bit moved off a carrier rise");
    property p_async_cause; $rose(async_mode) |-> !($past(rst_pin, 2) && $past(rst_pin, 5)); endproperty
    a_async_cause: assert property (p_async_cause) else $error("async mode without low reset pad");
    property p_prog_len; $fell(prog_busy) |-> busy_n_q inside {10'h271, 10'h272}; endproperty
    a_prog_len: assert property (p_prog_len) else $error("programming time wrong");
    property p_busy_quiet; !async_mode && prog_busy |-> !$rose(sda_oe); endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("answered while programming");
    property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("waiting word lost");
    property p_rx_zone; rx_valid && !async_mode |-> zone_wr_en[rx_data[16:15]]; endproperty
    a_rx_zone: assert property (p_rx_zone) else $error("word stored in locked zone");
endmodule

// *** tb/dpc_host_model.sv ***
// host side model: 2-wire master and async reader pads
`timescale 1ns/1ps
module dpc_host_model (
    output logic clk_pin, // serial clock or carrier
    output logic rst_pin, // card reset pad
    output logic host_low, // host pulls data line low
    input wire logic line // resolved data line
);
    logic car_en;
    ////////////////////////////////////////
    // idle pads: clock high, line released, reset pad high
    initial
    begin
        clk_pin = 1'b1;
        rst_pin = 1'b1;
        host_low = 1'b0;
        car_en = 1'b0;
        #0.25;
        // 8 MHz carrier, offset so it never meets a ref_clk edge
        forever
        begin
            #62.5;
            if (car_en)
                clk_pin = ~clk_pin;
        end
    end
    // one 1 us bit slot, data set while clock low
    task automatic bit_io(input logic b, output logic s);
        clk_pin = 1'b0;
        #100 host_low = ~b;
        #400 clk_pin = 1'b1;
        #250 s = line;
        #250;
    endtask
    task automatic start;
        host_low = 1'b1;
        #500;
    endtask
    task automatic stop;
        clk_pin = 1'b0;
        #100 host_low = 1'b1;
        #400 clk_pin = 1'b1;
        #500 host_low = 1'b0;
        #500;
    endtask
    // the header byte picks one device on the shared bus
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic more);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~more, s);
    endtask
endmodule

// *** tb/tb_dpc_card_if.sv ***
// self-checking bench of the card front end
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_dpc_card_if;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int tx_taken = 0; // bytes handed out, one per tx_ready pulse
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic crypt_en = 1'b0;
    logic [1:0] key_sel = 2'h0;
    logic [3:0] zone_wr_en = 4'hf;
    logic clk_pin, rst_pin, host_low, line, sda_out, sda_oe, rx_valid, tx_ready, async_mode, prog_busy, pw_ok;
    logic [16:0] rx_data;
    ////////////////////////////////////////
    // wired-and data line with pull-up
    assign line = (sda_oe ? sda_out : 1'b1) && !host_low;
    dpc_card_if dut (.ref_clk(ref_clk), .reset(reset), .clk_pin(clk_pin), .rst_pin(rst_pin), .sda_in(line),
        .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr(4'h5), .atr_data(64'h0123_4567_89ab_cd01),
        .zone_wr_en(zone_wr_en), .zone_rd_en(4'h2), .crypt_en(crypt_en), .key_sel(key_sel),
        .key_bytes(32'h113c_2233), .pw_sets(384'ha5c3e1 << 72), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .async_mode(async_mode), .prog_busy(prog_busy), .pw_ok(pw_ok));
    dpc_host_model u_host (.clk_pin(clk_pin), .rst_pin(rst_pin), .host_low(host_low), .line(line));
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    // hang guard, about twice the expected run
    always @(posedge ref_clk)
    begin
        tx_taken += (tx_ready === 1'b1) ? 1 : 0;
        cycles++;
        if (cycles == 80000)
        begin
            mismatches++;
            conclude();
        end
    end
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    // wait out programming, then header and offset
    task automatic go(input logic [7:0] hdr, input logic [7:0] ofs, output logic [1:0] a);
        for (int i = 0; i < 1000 && prog_busy !== 1'b0; i++)
            tick();
        u_host.start();
        u_host.wbyte(hdr, a[1]);
        u_host.wbyte(ofs, a[0]);
    endtask
    task automatic take(input logic [16:0] exp);
        for (int i = 0; i < 50 && rx_valid !== 1'b1; i++)
            tick();
        `CHK("rx word", exp, rx_data)
        rx_ready = 1'b1;
        tick();
        rx_ready = 1'b0;
        tick();
    endtask
    // page wrapping at 0x1f, buffer full, locked zone, foreign address
    task automatic t_write;
        logic [1:0] a;
        logic [2:0] d;
        go(8'h54, 8'h1f, a);
        u_host.wbyte(8'ha1, d[2]);
        u_host.wbyte(8'hb2, d[1]);
        u_host.wbyte(8'hc3, d[0]);
        u_host.stop();
        `CHK("page acks", 5'h1e, {a, d})
        `CHK("programming", 1'b1, prog_busy)
        take({2'h1, 7'h1f, 8'ha1});
        take({2'h1, 7'h10, 8'hb2});
        zone_wr_en = 4'hb;
        go(8'h58, 8'h00, a);
        u_host.wbyte(8'h77, d[0]);
        u_host.stop();
        `CHK("locked zone", 3'h6, {a, d[0]})
        go(8'h34, 8'h00, a);
        u_host.stop();
        `CHK("foreign address", 2'h0, a)
        `CHK("nothing stored", 1'b0, rx_valid)
        $display("write test done");
    endtask
    // encrypted read with key set 2, then a locked zone read while a byte is still offered
    task automatic t_read;
        logic [1:0] a;
        logic [7:0] d;
        tick();
        crypt_en = 1'b1;
        key_sel = 2'h2;
        tx_data = 8'h5a;
        tx_valid = 1'b1;
        go(8'h55, 8'h00, a);
        u_host.rbyte(d, 1'b0);
        u_host.stop();
        tick();
        crypt_en = 1'b0;
        `CHK("read acks", 2'h3, a)
        `CHK("read byte", 8'h66, d)
        go(8'h59, 8'h00, a);
        u_host.rbyte(d, 1'b0);
        u_host.stop();
        tick();
        tx_valid = 1'b0;
        `CHK("locked read", 8'hff, d)
        `CHK("bytes taken", 1, tx_taken)
        $display("read test done");
    endtask
    // password 3: right value, then off by one bit
    task automatic t_pw;
        logic [1:0] a;
        logic s;
        for (int k = 0; k < 2; k++)
        begin
            go(8'h56, 8'h03, a);
            u_host.wbyte(8'ha5, s);
            u_host.wbyte(8'hc3, s);
            u_host.wbyte(8'he1 ^ 8'(k), s);
            u_host.stop();
            `CHK("password match", 1'(1 - k), pw_ok)
        end
        $display("password test done");
    endtask
    // answer-to-reset start bit and first bit, aborted by reset
    task automatic t_async;
        int n;
        u_host.car_en = 1'b1;
        u_host.rst_pin = 1'b0;
        repeat (40) tick();
        `CHK("async entry", 1'b1, async_mode)
        u_host.rst_pin = 1'b1;
        for (n = 0; n < 100 && sda_oe !== 1'b1; n++)
            tick();
        `CHK("answer started", 1'b1, sda_oe)
        for (int b = 0; b < 2; b++)
        begin
            for (n = 0; n < 400 && sda_oe === 1'(1 - b); n++)
            begin
                @(posedge clk_pin);
                #40;
            end
            `CHK("bit length", 372, n)
        end
        tick();
        reset = 1'b1;
        tick();
        reset = 1'b0;
        tick();
        `CHK("abort quiet", 2'h0, {async_mode, sda_oe})
        u_host.car_en = 1'b0;
        $display("async test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (8) tick();
        t_write();
        t_read();
        t_pw();
        t_async();
        conclude();
    end
endmodule
bind dpc_card_if dpc_card_if_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .clk_pin(clk_pin),
    .rst_pin(rst_pin), .sda_out(sda_out), .sda_oe(sda_oe), .zone_wr_en(zone_wr_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .async_mode(async_mode), .prog_busy(prog_busy));
